// >>> src/charger_otg_pkg.sv
// Purpose: shared constants and carriers for the charger and step-up control block
// Assumes: 40 MHz core clock, 8-bit register port
// Notes: analog thresholds arrive as comparator levels from the power stage
package charger_otg_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [2:0] ADDR_CHARGE = 3'h0;
  localparam logic [2:0] ADDR_USB_LIM = 3'h1;
  localparam logic [2:0] ADDR_ADP_LIM = 3'h2;
  localparam logic [2:0] ADDR_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_FAULT = 3'h5;
  localparam logic [2:0] ADDR_IRQ_CTRL = 3'h6;

  // ***************************************************************
  // Field layout and reset values
  // ***************************************************************
  localparam logic [3:0] TRIM_FULL = 4'h0;
  localparam logic [3:0] TRIM_STEPS = 4'hE;
  localparam logic [4:0] LIMIT_DEFAULT = 5'h00;
  localparam int CTL_SAG_OFF = 0;
  localparam int CTL_INHIBIT = 1;
  localparam int CTL_PREFER_USB = 2;
  localparam int CTL_START = 3;
  localparam int IEN_OTG = 4;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Trickle reference level on the charge reference scale
  localparam logic [3:0] TRIM_TRICKLE = 4'hF;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int SHORT_DELAY_US = 8_000;
  localparam int SHORT_DELAY_CYC = CLK_HZ / 1_000_000 * SHORT_DELAY_US;
  localparam int CNT_W = 20;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic usb_good;
    logic adapter_good;
    logic cell_low;
    logic cell_below_trickle;
    logic id_grounded;
    logic boost_short;
  } power_sense_t;

  typedef struct packed {
    logic [3:0] charge_ref;
    logic [4:0] input_limit;
    logic from_usb;
    logic from_adapter;
    logic sag_limit_en;
    logic boost_en;
    logic charge_yield;
  } power_ctrl_t;

endpackage : charger_otg_pkg

// >>> src/level_sync.sv
// Purpose: two-stage synchroniser for one asynchronous level
// Assumes: single clock domain
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module level_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : level_sync

// >>> src/short_timer.sv
// Purpose: delay counter for the step-up short-circuit shutdown
// Assumes: fault level already synchronised
// Notes: restarts whenever the fault clears
`timescale 1ns/10ps
module short_timer #(
  parameter int DELAY_CYC = charger_otg_pkg::SHORT_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic fault_i,
  output logic expired_o
);
  localparam logic [charger_otg_pkg::CNT_W-1:0] TERMINAL =
    charger_otg_pkg::CNT_W'(DELAY_CYC - 1);

  logic [charger_otg_pkg::CNT_W-1:0] count_q;
  wire at_end = (count_q == TERMINAL);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_q <= '0;
      expired_o <= 1'b0;
    end
    else if (!fault_i)
    begin
      count_q <= '0;
      expired_o <= 1'b0;
    end
    else if (!at_end)
    begin
      count_q <= count_q + 1'b1;
      expired_o <= 1'b0;
    end
    else
    begin
      expired_o <= 1'b1;
    end
  end
endmodule : short_timer

// >>> src/charger_otg_control.sv
// Purpose: digital control of charger settings, input limits and step-up converter
// Assumes: comparator levels from the analog side are asynchronous
// Notes: plain register port, read data one cycle after the read strobe
//
// Contract
// - Charge reference defaults full scale; four-bit trim picks fourteen 6.25% reductions.
// - Below 2.94V reference falls toward trickle, reached below 2.8V depleted level.
// - Separate five-bit input limit per input, up to 3A, set by host.
// - USB limit returns to 100mA default whenever USB power is removed.
// - Adapter limit returns to default only when both inputs lack power.
// - Sag current limit near 4.3V is active unless the disable bit is set.
// - Step-up starts from grounded cable pin or the host start command.
// - Step-up blocked while either input is powered or battery is depleted.
// - Step-up feeds only the USB input; preference ignored while boosting.
// - Output short in step-up shuts converter after 8ms and sets fault.
// - Cable pin monitored always; status true whenever pin is grounded.
// - Change of cable detect status raises interrupt request when enabled.
// - Inhibit bit blocks only automatic start, not monitoring or status.
// - Host start command works regardless of cable detect or inhibit.
// - Detection flagged below about 24k, comparator decides; higher values ignored.
// - Running, depleted and short status bits tell host if step-up runs.
// - When load plus charge exceeds input, charge current yields first.
// - Full write to address 0x06 clears pending interrupts; reads have no effect.
// - Both inputs powered: adapter by default, USB when preference bit set.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/10ps
module charger_otg_control #(
  parameter int SHORT_DELAY_CYC = charger_otg_pkg::SHORT_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Analog comparators
  input wire logic usb_good_i,
  input wire logic adapter_good_i,
  input wire logic cell_low_i,
  input wire logic cell_below_trickle_i,
  input wire logic id_grounded_i,
  input wire logic boost_short_i,
  input wire logic overload_i,
  // Power stage control
  output charger_otg_pkg::power_ctrl_t ctrl_o,
  // Interrupt request to host
  output logic irq_o
);

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  charger_otg_pkg::power_sense_t sense_raw;
  charger_otg_pkg::power_sense_t sense;
  logic overload_s;

  assign sense_raw = '{usb_good: usb_good_i, adapter_good: adapter_good_i,
                       cell_low: cell_low_i, cell_below_trickle: cell_below_trickle_i,
                       id_grounded: id_grounded_i, boost_short: boost_short_i};

  genvar gi;
  generate
    for (gi = 0; gi < $bits(charger_otg_pkg::power_sense_t); gi++)
    begin : g_sync
      level_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(sense_raw[gi]),
        .q_o(sense[gi])
      );
    end
  endgenerate

  level_sync u_sync_ovl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(overload_i),
    .q_o(overload_s)
  );

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [3:0] trim_q;
  logic [4:0] usb_lim_q;
  logic [4:0] adp_lim_q;
  logic sag_off_q;
  logic inhibit_q;
  logic prefer_usb_q;
  logic start_cmd_q;
  logic otg_irq_en_q;
  logic irq_pend_q;
  logic id_prev_q;
  logic short_flag_q;
  logic running_q;
  logic expired;

  wire wr_charge = wr_i && (addr_i == charger_otg_pkg::ADDR_CHARGE);
  wire wr_usb = wr_i && (addr_i == charger_otg_pkg::ADDR_USB_LIM);
  wire wr_adp = wr_i && (addr_i == charger_otg_pkg::ADDR_ADP_LIM);
  wire wr_ctl = wr_i && (addr_i == charger_otg_pkg::ADDR_CONTROL);
  wire wr_irq = wr_i && (addr_i == charger_otg_pkg::ADDR_IRQ_CTRL);

  wire any_input = sense.usb_good || sense.adapter_good;
  wire usb_lost = !sense.usb_good;
  wire both_lost = !sense.usb_good && !sense.adapter_good;
  wire id_change = sense.id_grounded != id_prev_q;

  // Trim values above the last step clamp to the last, deepest reduction step
  wire [3:0] trim_clamped = (wdata_i[3:0] > charger_otg_pkg::TRIM_STEPS) ?
                            charger_otg_pkg::TRIM_STEPS : wdata_i[3:0];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      trim_q <= charger_otg_pkg::TRIM_FULL;
    else if (wr_charge)
      trim_q <= trim_clamped;
  end

  // Loss of power beats a simultaneous host write, so a stale limit never survives
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      usb_lim_q <= charger_otg_pkg::LIMIT_DEFAULT;
    else if (usb_lost)
      usb_lim_q <= charger_otg_pkg::LIMIT_DEFAULT;
    else if (wr_usb)
      usb_lim_q <= wdata_i[4:0];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      adp_lim_q <= charger_otg_pkg::LIMIT_DEFAULT;
    else if (both_lost)
      adp_lim_q <= charger_otg_pkg::LIMIT_DEFAULT;
    else if (wr_adp)
      adp_lim_q <= wdata_i[4:0];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sag_off_q <= 1'b0;
      inhibit_q <= 1'b0;
      prefer_usb_q <= 1'b0;
      start_cmd_q <= 1'b0;
    end
    else if (wr_ctl)
    begin
      sag_off_q <= wdata_i[charger_otg_pkg::CTL_SAG_OFF];
      inhibit_q <= wdata_i[charger_otg_pkg::CTL_INHIBIT];
      prefer_usb_q <= wdata_i[charger_otg_pkg::CTL_PREFER_USB];
      start_cmd_q <= wdata_i[charger_otg_pkg::CTL_START];
    end
  end

  // Set wins over the clear written in the same cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      otg_irq_en_q <= 1'b0;
      irq_pend_q <= 1'b0;
      id_prev_q <= 1'b0;
    end
    else
    begin
      id_prev_q <= sense.id_grounded;
      if (wr_irq)
        otg_irq_en_q <= wdata_i[charger_otg_pkg::IEN_OTG];
      if (id_change && otg_irq_en_q)
        irq_pend_q <= 1'b1;
      else if (wr_irq)
        irq_pend_q <= 1'b0;
    end
  end

  // ***************************************************************
  // Step-up converter control
  // ***************************************************************
  wire auto_start = sense.id_grounded && !inhibit_q;
  wire boost_want = auto_start || start_cmd_q;
  wire boost_block = any_input || sense.cell_low || short_flag_q;
  wire boost_next = boost_want && !boost_block;

  short_timer #(
    .DELAY_CYC(SHORT_DELAY_CYC)
  ) u_short (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fault_i(sense.boost_short && running_q),
    .expired_o(expired)
  );

  // Fault latches until the request goes away, so the converter cannot retry on its own
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      short_flag_q <= 1'b0;
      running_q <= 1'b0;
    end
    else
    begin
      if (expired)
        short_flag_q <= 1'b1;
      else if (!boost_want)
        short_flag_q <= 1'b0;
      running_q <= boost_next && !expired;
    end
  end

  // ***************************************************************
  // Power stage outputs
  // ***************************************************************
  charger_otg_pkg::power_ctrl_t ctrl_d;
  wire use_usb = sense.usb_good && (!sense.adapter_good || prefer_usb_q);
  wire use_adp = sense.adapter_good && !use_usb;
  wire [3:0] ref_lowcell = sense.cell_below_trickle ? charger_otg_pkg::TRIM_TRICKLE :
                           (trim_q | 4'h8);

  always_comb
  begin
    ctrl_d.charge_ref = sense.cell_low ? ref_lowcell : trim_q;
    ctrl_d.input_limit = use_usb ? usb_lim_q : adp_lim_q;
    ctrl_d.from_usb = running_q ? 1'b1 : use_usb;
    ctrl_d.from_adapter = running_q ? 1'b0 : use_adp;
    ctrl_d.sag_limit_en = !sag_off_q;
    ctrl_d.boost_en = running_q;
    ctrl_d.charge_yield = overload_s;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_o <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      ctrl_o <= ctrl_d;
      irq_o <= irq_pend_q;
    end
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  logic [7:0] rmux;
  always_comb
  begin
    case (addr_i)
      charger_otg_pkg::ADDR_CHARGE: rmux = {4'h0, trim_q};
      charger_otg_pkg::ADDR_USB_LIM: rmux = {3'h0, usb_lim_q};
      charger_otg_pkg::ADDR_ADP_LIM: rmux = {3'h0, adp_lim_q};
      charger_otg_pkg::ADDR_CONTROL: rmux = {4'h0, start_cmd_q, prefer_usb_q,
                                              inhibit_q, sag_off_q};
      charger_otg_pkg::ADDR_STATUS: rmux = {3'h0, sense.cell_low, running_q,
                                             sense.id_grounded, sense.adapter_good,
                                             sense.usb_good};
      charger_otg_pkg::ADDR_FAULT: rmux = {7'h00, short_flag_q};
      charger_otg_pkg::ADDR_IRQ_CTRL: rmux = {3'h0, otg_irq_en_q, 3'h0, irq_pend_q};
      default: rmux = charger_otg_pkg::ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= charger_otg_pkg::ZERO_BYTE;
    else if (rd_i)
      rdata_o <= rmux;
    else
      rdata_o <= charger_otg_pkg::ZERO_BYTE;
  end

endmodule : charger_otg_control

// >>> testbench/charger_otg_properties.sv
// Purpose: port checks for charger_otg_control
// Assumes: bound to the design top, sense inputs reach ctrl_o within 4 or 5 cycles
// Notes: short timer bound kept by a helper counter
`timescale 1ns/10ps
module charger_otg_properties #(
  parameter int SHORT_DELAY_CYC = 20
) (
  // Clock, reset, register port
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic wr_i,
  // Sense and control
  input wire logic usb_good_i,
  input wire logic adapter_good_i,
  input wire logic cell_low_i,
  input wire logic cell_below_trickle_i,
  input wire logic boost_short_i,
  input wire logic overload_i,
  input wire charger_otg_pkg::power_ctrl_t ctrl_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  int unsigned run_q;
  logic irq_clr_q;
  wire irq_wr = wr_i && (addr_i == charger_otg_pkg::ADDR_IRQ_CTRL);
  // Counts cycles of a short while boosting; the clear write shows on irq_o one cycle late
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_q <= 0;
      irq_clr_q <= 1'b0;
    end
    else
    begin
      run_q <= (ctrl_o.boost_en && boost_short_i) ? run_q + 1 : 0;
      irq_clr_q <= irq_wr;
    end
  end
  // Running state sits one register behind the synchronisers, hence five samples
  chk_boost_input: assert property ((usb_good_i || adapter_good_i)[*5] |-> !ctrl_o.boost_en)
    else $error("boost with input power");
  chk_boost_cell: assert property (cell_low_i[*5] |-> !ctrl_o.boost_en)
    else $error("boost with depleted cell");
  chk_boost_path: assert property (ctrl_o.boost_en |-> ctrl_o.from_usb && !ctrl_o.from_adapter)
    else $error("boost not on usb path");
  chk_one_path: assert property ((usb_good_i && adapter_good_i)[*4]
    |-> ctrl_o.from_usb != ctrl_o.from_adapter)
    else $error("input path not unique");
  chk_path_excl: assert property (!(ctrl_o.from_usb && ctrl_o.from_adapter))
    else $error("both input paths selected");
  chk_short_bound: assert property (run_q <= SHORT_DELAY_CYC + 8)
    else $error("short shutdown too late");
  chk_limit_dflt: assert property ((!usb_good_i && !adapter_good_i)[*5]
    |-> ctrl_o.input_limit == charger_otg_pkg::LIMIT_DEFAULT)
    else $error("limit not default");
  chk_yield_load: assert property (overload_i[*4] |-> ctrl_o.charge_yield)
    else $error("charge did not yield");
  chk_trickle_ref: assert property ((cell_low_i && cell_below_trickle_i)[*4]
    |-> ctrl_o.charge_ref == charger_otg_pkg::TRIM_TRICKLE)
    else $error("trickle reference wrong");
  chk_irq_hold: assert property (irq_o && !irq_wr && !irq_clr_q |=> irq_o)
    else $error("interrupt dropped early");
  cover property ($rose(ctrl_o.boost_en));
  cover property ($rose(irq_o));
  cover property ($fell(ctrl_o.boost_en) && boost_short_i);
endmodule : charger_otg_properties

bind charger_otg_control charger_otg_properties #(
  .SHORT_DELAY_CYC(SHORT_DELAY_CYC)
) u_props (.clk_i, .rst_i, .addr_i, .wr_i, .usb_good_i, .adapter_good_i, .cell_low_i,
  .cell_below_trickle_i, .boost_short_i, .overload_i, .ctrl_o, .irq_o);

// >>> testbench/host_model.sv
// Purpose: host side of the register port
// Assumes: strobes launched right after a rising edge
// Notes: data lines show the inverse once a write is over
`timescale 1ns/10ps
module host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [2:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial
  begin
    addr_o = 3'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : host_model

// >>> testbench/charger_otg_control_tb.sv
// Purpose: self-checking bench for charger_otg_control
// Assumes: short delay shortened to 20 cycles
// Notes: sense bits are usb, adapter, low, trickle, id, short
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
  begin \
    total_checks++; \
    if ((gt) !== (ex)) \
    begin \
      n_fail++; \
      $display("[FAIL] %s exp %h got %h", nm, ex, gt); \
    end \
  end
module charger_otg_control_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] d;
  logic wr;
  logic rd;
  logic ovl = 1'b0;
  logic irq;
  logic [3:0] t;
  logic [4:0] lim;
  charger_otg_pkg::power_sense_t s = '0;
  charger_otg_pkg::power_ctrl_t ctrl;
  int n_fail = 0;
  int total_checks = 0;
  always #12.5 clk_i = ~clk_i;
  charger_otg_control #(.SHORT_DELAY_CYC(20)) DUT (.clk_i, .rst_i, .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .usb_good_i(s.usb_good),
    .adapter_good_i(s.adapter_good), .cell_low_i(s.cell_low),
    .cell_below_trickle_i(s.cell_below_trickle), .id_grounded_i(s.id_grounded),
    .boost_short_i(s.boost_short), .overload_i(ovl), .ctrl_o(ctrl), .irq_o(irq));
  host_model host (.clk_i, .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));
  function automatic logic [3:0] exp_ref(input logic [3:0] tr, input logic lo, input logic tk);
    logic [3:0] c;
    c = (tr > 4'hE) ? 4'hE : tr;
    return lo ? (tk ? charger_otg_pkg::TRIM_TRICKLE : (c | 4'h8)) : c;
  endfunction : exp_ref
  function automatic logic [7:0] exp_stat(input logic run);
    return {3'h0, s.cell_low, run, s.id_grounded, s.adapter_good, s.usb_good};
  endfunction : exp_stat
  task automatic put(input logic [5:0] v);
    @(posedge clk_i);
    s <= v;
    repeat (5) @(posedge clk_i);
  endtask : put
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(13));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    host.rd(charger_otg_pkg::ADDR_CHARGE, d);
    `CHK("trim", 8'h00, d)
    `CHK("sag", 1'b1, ctrl.sag_limit_en)
    host.rd(3'h7, d);
    `CHK("unmapped", 8'h00, d)
    for (int i = 0; i < 6; i++)
    begin
      t = (i == 0) ? 4'hF : 4'($urandom_range(14));
      host.wr(charger_otg_pkg::ADDR_CHARGE, {4'h0, t});
      repeat (2) @(posedge clk_i);
      `CHK("ref", exp_ref(t, 1'b0, 1'b0), ctrl.charge_ref)
    end
    put(6'b001000);
    `CHK("ramp", exp_ref(t, 1'b1, 1'b0), ctrl.charge_ref)
    put(6'b001100);
    `CHK("trickle", exp_ref(t, 1'b1, 1'b1), ctrl.charge_ref)
    ovl <= 1'b1;
    put(6'b110000);
    `CHK("yield", 1'b1, ctrl.charge_yield)
    ovl <= 1'b0;
    host.wr(charger_otg_pkg::ADDR_CONTROL, 8'h01);
    repeat (2) @(posedge clk_i);
    `CHK("sag off", 1'b0, ctrl.sag_limit_en)
    lim = 5'($urandom());
    host.wr(charger_otg_pkg::ADDR_USB_LIM, {3'h0, lim});
    host.wr(charger_otg_pkg::ADDR_ADP_LIM, {3'h0, ~lim});
    repeat (2) @(posedge clk_i);
    `CHK("adp lim", ~lim, ctrl.input_limit)
    host.wr(charger_otg_pkg::ADDR_CONTROL, 8'h04);
    repeat (2) @(posedge clk_i);
    `CHK("usb lim", lim, ctrl.input_limit)
    put(6'b010000);
    host.rd(charger_otg_pkg::ADDR_USB_LIM, d);
    `CHK("usb reset", 8'h00, d)
    host.rd(charger_otg_pkg::ADDR_ADP_LIM, d);
    `CHK("adp kept", {3'h0, ~lim}, d)
    `CHK("adp path", 1'b1, ctrl.from_adapter)
    put(6'b000000);
    host.rd(charger_otg_pkg::ADDR_ADP_LIM, d);
    `CHK("adp reset", 8'h00, d)
    host.wr(charger_otg_pkg::ADDR_CONTROL, 8'h00);
    put(6'b000010);
    `CHK("auto", 1'b1, ctrl.boost_en)
    `CHK("usb path", 1'b1, ctrl.from_usb)
    host.rd(charger_otg_pkg::ADDR_STATUS, d);
    `CHK("stat", exp_stat(1'b1), d)
    host.wr(charger_otg_pkg::ADDR_CONTROL, 8'h02);
    repeat (3) @(posedge clk_i);
    `CHK("inhibit", 1'b0, ctrl.boost_en)
    host.rd(charger_otg_pkg::ADDR_STATUS, d);
    `CHK("stat inh", exp_stat(1'b0), d)
    host.wr(charger_otg_pkg::ADDR_CONTROL, 8'h0A);
    put(6'b000000);
    `CHK("cmd", 1'b1, ctrl.boost_en)
    put(6'b010000);
    `CHK("blk adp", 1'b0, ctrl.boost_en)
    put(6'b001000);
    `CHK("blk low", 1'b0, ctrl.boost_en)
    host.rd(charger_otg_pkg::ADDR_STATUS, d);
    `CHK("stat low", exp_stat(1'b0), d)
    put(6'b000000);
    for (int k = 0; k < 2; k++)
    begin
      s.boost_short <= 1'b1;
      repeat (12) @(posedge clk_i);
      s.boost_short <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    `CHK("restart", 1'b1, ctrl.boost_en)
    s.boost_short <= 1'b1;
    repeat (15) @(posedge clk_i);
    `CHK("short hold", 1'b1, ctrl.boost_en)
    repeat (15) @(posedge clk_i);
    `CHK("short off", 1'b0, ctrl.boost_en)
    host.rd(charger_otg_pkg::ADDR_FAULT, d);
    `CHK("fault", 8'h01, d)
    s.boost_short <= 1'b0;
    host.wr(charger_otg_pkg::ADDR_IRQ_CTRL, 8'h10);
    put(6'b000010);
    `CHK("irq", 1'b1, irq)
    host.rd(charger_otg_pkg::ADDR_IRQ_CTRL, d);
    `CHK("irq reg", 8'h11, d)
    `CHK("irq kept", 1'b1, irq)
    host.wr(charger_otg_pkg::ADDR_IRQ_CTRL, 8'h10);
    repeat (2) @(posedge clk_i);
    `CHK("irq clr", 1'b0, irq)
    host.wr(charger_otg_pkg::ADDR_IRQ_CTRL, 8'h00);
    put(6'b000000);
    `CHK("irq mask", 1'b0, irq)
    report_and_stop();
  end
endmodule : charger_otg_control_tb
